//--- dsf_pkg.sv
// constants and types for the dac special-function decoder
package dsf_pkg;
	// serial word layout
	localparam logic [4:0] WORD_BITS = 5'h18;
	localparam int MODE_HI = 23;
	localparam int MODE_LO = 22;
	localparam int CODE_HI = 21;
	localparam int CODE_LO = 16;
	localparam logic [1:0] MODE_SPECIAL = 2'h0;
	// special function codes
	localparam logic [5:0] SF_READBACK = 6'h05;
	localparam logic [5:0] SF_BLOCK_BANK = 6'h0B;
	localparam logic [5:0] SF_MONITOR = 6'h0C;
	localparam logic [5:0] SF_GPIO = 6'h0D;
	// readback address field, operand bits 15..7
	localparam int RB_ADDR_HI = 15;
	localparam int RB_ADDR_LO = 7;
	localparam int RB_SRC_HI = 8;
	localparam int RB_SRC_LO = 6;
	localparam int RB_CHAN_HI = 5;
	localparam int RB_CHAN_LO = 0;
	localparam logic [8:0] RB_CTRL = 9'h101;
	localparam logic [8:0] RB_OFFSET_DAC_0_VALUE = 9'h102;
	localparam logic [8:0] RB_OFFSET_DAC_1_VALUE = 9'h103;
	localparam logic [8:0] RB_BANK0 = 9'h106;
	localparam logic [8:0] RB_BANK1 = 9'h107;
	localparam logic [8:0] RB_GPIO = 9'h10B;
	// monitor operand fields
	localparam int MON_EN_BIT = 5;
	localparam int MON_EXT_BIT = 4;
	localparam int MON_CH_HI = 3;
	localparam int MON_CH_LO = 0;
	localparam int MON_PIN_BIT = 0;
	// gpio operand fields
	localparam int GPIO_DIR_BIT = 1;
	localparam int GPIO_VAL_BIT = 0;
	// reset values
	localparam logic [7:0] BANK_SEL_RST = 8'h00;
	localparam logic [3:0] MON_CH_RST = 4'h0;
	localparam logic [8:0] RB_ADDR_RST = 9'h000;
	localparam logic [23:0] SHIFT_RST = 24'h000000;
	localparam logic [4:0] CNT_RST = 5'h00;
	// frame tracking
	typedef enum logic {DSF_FR_IDLE, DSF_FR_SHIFT} dsf_frame_e;
endpackage

//--- dsf_sync.sv
// two-flop synchroniser for a level from outside the system clock domain
`timescale 1ns/1ps
module dsf_sync
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// level in and out
	input wire logic async_i,
	output logic sync_o
);
	logic meta_q;

	// first flop feeds only the second one
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			meta_q <= 1'b0;
			sync_o <= 1'b0;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule

//--- dsf_decoder.sv
// serial special-function decoder: bank select, monitor mux, gpio, readback
//
// Contract
// [R1] mode 00 means special function, code 21..16
// [R2] block write: zeros pick bank A, ones B
// [R3] monitor bit 5 enables the monitor mux
// [R4] bit 4 clear routes dac channel bits 3..0
// [R5] bits 4,5 set route external input by bit0
// [R6] gpio bit1 set drives pin with bit 0
// [R7] gpio bit1 clear makes pin input, readable
// [R8] readback bits 15..13 pick channel source
// [R9] system codes return control, offset, bank registers
// [R10] readback ignores operand bits 6..0
// [R11] readback code 10B returns gpio level bit 0
// [R12] bank reg 0 is ch7..0, reg 1 ch15..8
// [R13] bank bit 0 uses A, 1 uses B
// [R14] host reads via select, then nop frame
// [R15] reserved codes change nothing, read zero
`timescale 1ns/1ps
module dsf_decoder
	import dsf_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// serial link pins, asynchronous to sys_clk_i
	input wire logic sclk_i,
	input wire logic sync_b_i,
	input wire logic sdi_i,
	output logic sdo_o,
	// general-purpose pin
	input wire logic gpio_i,
	output logic gpio_o,
	output logic gpio_oe_o,
	// per-channel second input bank, bit n is channel n, 1 = bank B
	output logic [15:0] bank_sel_o,
	// monitor multiplexer control
	output logic mon_en_o,
	output logic mon_ext_o,
	output logic [3:0] mon_chan_o,
	output logic mon_pin_o,
	// channel readback request to the data path, and its answer
	output logic [2:0] rb_src_o,
	output logic [5:0] rb_chan_o,
	input wire logic [15:0] rb_chan_data_i,
	// system registers held elsewhere, same clock domain
	input wire logic [15:0] ctrl_reg_i,
	input wire logic [15:0] offset_dac_0_value_i,
	input wire logic [15:0] offset_dac_1_value_i
);
	logic sclk_s;
	logic sync_b_s;
	logic sdi_s;
	logic gpio_s;

	// every pin level crosses two flops before use
	dsf_sync u_sync_sclk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .async_i(sclk_i), .sync_o(sclk_s));
	dsf_sync u_sync_fr (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .async_i(sync_b_i), .sync_o(sync_b_s));
	dsf_sync u_sync_sdi (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .async_i(sdi_i), .sync_o(sdi_s));
	dsf_sync u_sync_gpio (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .async_i(gpio_i), .sync_o(gpio_s));

	dsf_frame_e frame_q, frame_d;
	logic sclk_q;
	logic sync_b_q;
	logic [4:0] cnt_q, cnt_d;
	logic [23:0] shin_q, shin_d;
	logic [23:0] shout_q, shout_d;
	logic sdo_d;
	logic word_ok;
	logic [15:0] rb_data;

	// edges of the sampled link signals; sdi is sampled on sclk falling
	logic sclk_fall;
	logic sclk_rise;
	logic frame_start;
	logic frame_end;
	assign sclk_fall = sclk_q & ~sclk_s;
	assign sclk_rise = ~sclk_q & sclk_s;
	assign frame_start = sync_b_q & ~sync_b_s;
	assign frame_end = ~sync_b_q & sync_b_s;
	// a frame counts only with exactly 24 bits; short or long frames are dropped
	assign word_ok = (frame_q == DSF_FR_SHIFT) && frame_end && (cnt_q == WORD_BITS);

	logic [7:0] bank_lo_q, bank_lo_d;
	logic [7:0] bank_hi_q, bank_hi_d;
	logic mon_en_d, mon_ext_d, mon_pin_d;
	logic [3:0] mon_chan_d;
	logic gpio_d, gpio_oe_d;
	logic [8:0] rb_addr_q, rb_addr_d;
	logic rb_pend_q, rb_pend_d;

	// readback source mux, sampled at the start of the following frame
	always_comb
	begin
		rb_data = 16'h0000;
		if (!rb_addr_q[RB_SRC_HI]) // [R8]
		begin
			rb_data = rb_chan_data_i;
		end
		else if (rb_addr_q == RB_CTRL) // [R9]
		begin
			rb_data = ctrl_reg_i;
		end
		else if (rb_addr_q == RB_OFFSET_DAC_0_VALUE)
		begin
			rb_data = offset_dac_0_value_i;
		end
		else if (rb_addr_q == RB_OFFSET_DAC_1_VALUE)
		begin
			rb_data = offset_dac_1_value_i;
		end
		else if (rb_addr_q == RB_BANK0)
		begin
			rb_data = {8'h00, bank_lo_q};
		end
		else if (rb_addr_q == RB_BANK1)
		begin
			rb_data = {8'h00, bank_hi_q};
		end
		else if (rb_addr_q == RB_GPIO)
		begin
			rb_data = {15'h0000, gpio_s}; // [R11] [R7]
		end
		else
		begin
			rb_data = 16'h0000; // [R15]
		end
	end

	// frame tracking, input shift and output shift
	always_comb
	begin
		frame_d = frame_q;
		cnt_d = cnt_q;
		shin_d = shin_q;
		shout_d = shout_q;
		sdo_d = sdo_o;
		case (frame_q)
			DSF_FR_IDLE:
			begin
				if (frame_start)
				begin
					frame_d = DSF_FR_SHIFT;
					cnt_d = CNT_RST;
					// data is loaded whole so later writes cannot tear it mid-frame
					shout_d = rb_pend_q ? {8'h00, rb_data} : SHIFT_RST; // [R14]
					sdo_d = rb_pend_q ? 1'b0 : 1'b0;
				end
			end
			DSF_FR_SHIFT:
			begin
				if (frame_end)
				begin
					frame_d = DSF_FR_IDLE;
					sdo_d = 1'b0;
				end
				else
				begin
					if (sclk_rise)
					begin
						sdo_d = shout_q[23];
						shout_d = {shout_q[22:0], 1'b0};
					end
					if (sclk_fall && (cnt_q != 5'h1F))
					begin
						shin_d = {shin_q[22:0], sdi_s};
						cnt_d = cnt_q + 5'h01;
					end
				end
			end
			default:
			begin
				frame_d = DSF_FR_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			frame_q <= DSF_FR_IDLE;
			sclk_q <= 1'b0;
			sync_b_q <= 1'b0; // same as the synchroniser's reset, so no false frame start
			cnt_q <= CNT_RST;
			shin_q <= SHIFT_RST;
			shout_q <= SHIFT_RST;
			sdo_o <= 1'b0;
		end
		else
		begin
			frame_q <= frame_d;
			sclk_q <= sclk_s;
			sync_b_q <= sync_b_s;
			cnt_q <= cnt_d;
			shin_q <= shin_d;
			shout_q <= shout_d;
			sdo_o <= sdo_d;
		end
	end

	// command execution on a complete word
	always_comb
	begin
		bank_lo_d = bank_lo_q;
		bank_hi_d = bank_hi_q;
		mon_en_d = mon_en_o;
		mon_ext_d = mon_ext_o;
		mon_chan_d = mon_chan_o;
		mon_pin_d = mon_pin_o;
		gpio_d = gpio_o;
		gpio_oe_d = gpio_oe_o;
		rb_addr_d = rb_addr_q;
		rb_pend_d = rb_pend_q;
		// a pending readback is consumed by the next frame of any kind
		if (frame_start)
		begin
			rb_pend_d = 1'b0;
		end
		if (word_ok && (shin_q[MODE_HI:MODE_LO] == MODE_SPECIAL)) // [R1]
		begin
			if (shin_q[CODE_HI:CODE_LO] == SF_BLOCK_BANK)
			begin
				bank_lo_d = shin_q[7:0]; // [R2]
				bank_hi_d = shin_q[7:0];
			end
			else if (shin_q[CODE_HI:CODE_LO] == SF_MONITOR)
			begin
				mon_en_d = shin_q[MON_EN_BIT]; // [R3]
				mon_ext_d = shin_q[MON_EXT_BIT]; // [R5]
				mon_chan_d = shin_q[MON_CH_HI:MON_CH_LO]; // [R4]
				mon_pin_d = shin_q[MON_PIN_BIT]; // [R5]
			end
			else if (shin_q[CODE_HI:CODE_LO] == SF_GPIO)
			begin
				gpio_oe_d = shin_q[GPIO_DIR_BIT]; // [R6] [R7]
				gpio_d = shin_q[GPIO_DIR_BIT] ? shin_q[GPIO_VAL_BIT] : gpio_o; // [R6]
			end
			else if (shin_q[CODE_HI:CODE_LO] == SF_READBACK)
			begin
				rb_addr_d = shin_q[RB_ADDR_HI:RB_ADDR_LO]; // [R10]
				rb_pend_d = 1'b1; // [R14]
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			bank_lo_q <= BANK_SEL_RST;
			bank_hi_q <= BANK_SEL_RST;
			bank_sel_o <= {BANK_SEL_RST, BANK_SEL_RST};
			mon_en_o <= 1'b0;
			mon_ext_o <= 1'b0;
			mon_chan_o <= MON_CH_RST;
			mon_pin_o <= 1'b0;
			gpio_o <= 1'b0;
			gpio_oe_o <= 1'b0;
			rb_addr_q <= RB_ADDR_RST;
			rb_pend_q <= 1'b0;
			rb_src_o <= 3'h0;
			rb_chan_o <= 6'h00;
		end
		else
		begin
			bank_lo_q <= bank_lo_d;
			bank_hi_q <= bank_hi_d;
			bank_sel_o <= {bank_hi_d, bank_lo_d}; // [R12] [R13]
			mon_en_o <= mon_en_d;
			mon_ext_o <= mon_ext_d;
			mon_chan_o <= mon_chan_d;
			mon_pin_o <= mon_pin_d;
			gpio_o <= gpio_d;
			gpio_oe_o <= gpio_oe_d;
			rb_addr_q <= rb_addr_d;
			rb_pend_q <= rb_pend_d;
			rb_src_o <= rb_addr_d[RB_SRC_HI:RB_SRC_LO]; // [R8]
			rb_chan_o <= rb_addr_d[RB_CHAN_HI:RB_CHAN_LO];
		end
	end
endmodule

//--- dsf_props.sv
// port checks for the special-function decoder
`timescale 1ns/1ps
module dsf_props
(
	// clock, reset, frame
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic sync_b_i,
	// watched outputs
	input wire logic sdo_o,
	input wire logic gpio_o,
	input wire logic gpio_oe_o,
	input wire logic [15:0] bank_sel_o,
	input wire logic mon_en_o,
	input wire logic mon_ext_o,
	input wire logic [3:0] mon_chan_o,
	input wire logic mon_pin_o,
	input wire logic [2:0] rb_src_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	// two sync flops plus the execute flop: a change shows on the third sampled edge
	// after the frame select is first seen high, never mid frame
	bank_after_frame_a: assert property ($changed(bank_sel_o) |->
		$past(sync_b_i, 3) && !$past(sync_b_i, 4)) else $error("bank moved");
	mon_en_hold_a: assert property (!sync_b_i [*6] |-> $stable(mon_en_o))
		else $error("monitor enable moved");
	mon_chan_late_a: assert property ($changed(mon_chan_o) |->
		$past(sync_b_i, 3) && !$past(sync_b_i, 4)) else $error("channel moved");
	mon_pin_hold_a: assert property (!sync_b_i [*6] |->
		$stable(mon_pin_o) && $stable(mon_ext_o)) else $error("pin moved");
	gpio_val_late_a: assert property ($changed(gpio_o) |->
		$past(sync_b_i, 3) && !$past(sync_b_i, 4)) else $error("gpio moved");
	gpio_dir_hold_a: assert property (!sync_b_i [*6] |-> $stable(gpio_oe_o))
		else $error("gpio enable moved");
	rb_addr_late_a: assert property ($changed(rb_src_o) |->
		$past(sync_b_i, 3) && !$past(sync_b_i, 4)) else $error("address moved");
	sdo_idle_a: assert property (sync_b_i [*8] |-> !sdo_o)
		else $error("sdo busy outside frame");
	cover property (mon_en_o && mon_ext_o);
	cover property (gpio_oe_o && gpio_o);
	cover property (bank_sel_o == 16'hFFFF);
endmodule

//--- dsf_host.sv
// host serial controller model
`timescale 1ns/1ps
module dsf_host
(
	// serial pins
	output logic sclk_o,
	output logic sync_b_o,
	output logic sdi_o,
	input wire logic sdo_i
);
	initial
	begin
		sclk_o = 1'b0;
		sync_b_o = 1'b1;
		sdi_o = 1'b0;
	end
	// one 24-bit frame, msb first; sclk stands still between frames
	// every pin change lands on a falling system clock edge, away from the sampling edge
	task automatic xfer(input logic [23:0] w, output logic [23:0] r);
		sync_b_o = 1'b0;
		#40;
		for (int i = 23; i >= 0; i--)
		begin
			sdi_o = w[i];
			#24 sclk_o = 1'b1;
			#40 sclk_o = 1'b0;
			r = {r[22:0], sdo_i};
			#16;
		end
		sync_b_o = 1'b1;
		// released line must not look like held data
		sdi_o = ~sdi_o;
		#40;
	endtask
endmodule

//--- dsf_decoder_tb.sv
// self-checking bench for the special-function decoder
`timescale 1ns/1ps
module dsf_decoder_tb import dsf_pkg::*;;
	logic sys_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic gpio_i = 1'b0;
	logic sclk, sync_b, sdi, sdo, gpio_o, gpio_oe, mon_en, mon_ext, mon_pin;
	logic [15:0] bank_sel;
	logic [3:0] mon_chan;
	logic [2:0] rb_src;
	logic [5:0] rb_chan;
	logic [23:0] rd;
	logic [15:0] mon_op [4] = '{16'h002F, 16'h0031, 16'h0030, 16'h0000};
	logic [6:0] mon_exp [4] = '{7'h5F, 7'h63, 7'h60, 7'h00};
	logic [8:0] sys_a [4] = '{RB_CTRL, RB_OFFSET_DAC_0_VALUE, RB_OFFSET_DAC_1_VALUE, 9'h104};
	logic [15:0] sys_e [4] = '{16'h1234, 16'h2345, 16'h3456, 16'h0000};
	int fails = 0;
	int comparisons = 0;
	int cyc = 0;
	always #4 sys_clk_i = ~sys_clk_i;
	dsf_host host_u (.sclk_o(sclk), .sync_b_o(sync_b), .sdi_o(sdi), .sdo_i(sdo));
	// data path stand-in answers with the address it was asked for
	dsf_decoder dut_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk),
		.sync_b_i(sync_b), .sdi_i(sdi), .sdo_o(sdo), .gpio_i(gpio_i), .gpio_o(gpio_o),
		.gpio_oe_o(gpio_oe), .bank_sel_o(bank_sel), .mon_en_o(mon_en), .mon_ext_o(mon_ext),
		.mon_chan_o(mon_chan), .mon_pin_o(mon_pin), .rb_src_o(rb_src), .rb_chan_o(rb_chan),
		.rb_chan_data_i({4'hA, 3'h0, rb_src, rb_chan}), .ctrl_reg_i(16'h1234),
		.offset_dac_0_value_i(16'h2345), .offset_dac_1_value_i(16'h3456));
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one command, then let the outputs settle
	task automatic wr(input logic [1:0] m, input logic [5:0] c, input logic [15:0] op);
		logic [23:0] r;
		host_u.xfer({m, c, op}, r);
		repeat (4) @(negedge sys_clk_i);
	endtask
	task automatic rdb(input logic [8:0] a, input logic [6:0] lo, output logic [23:0] r);
		wr(MODE_SPECIAL, SF_READBACK, {a, lo});
		host_u.xfer(24'h000000, r);
	endtask
	task automatic end_sim();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// hang guard, about three times the expected run
	always @(posedge sys_clk_i)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			fails++;
			end_sim();
		end
	end
	initial
	begin
		repeat (6) @(negedge sys_clk_i);
		rst_b_i = 1'b1;
		repeat (4) @(negedge sys_clk_i);
		chk({bank_sel, mon_en, gpio_oe, sdo}, 24'h0);
		wr(MODE_SPECIAL, SF_BLOCK_BANK, 16'h00FF);
		chk(bank_sel, 24'h00FFFF);
		rdb(RB_BANK1, 7'h7F, rd);
		chk(rd, 24'h0000FF);
		rdb(RB_BANK0, 7'h00, rd);
		chk(rd, 24'h0000FF);
		wr(2'h3, SF_BLOCK_BANK, 16'h0000);
		wr(MODE_SPECIAL, 6'h08, 16'h0000);
		chk(bank_sel, 24'h00FFFF);
		wr(MODE_SPECIAL, SF_BLOCK_BANK, 16'h0000);
		chk(bank_sel, 24'h0);
		$display("test bank done");
		for (int i = 0; i < 4; i++)
		begin
			wr(MODE_SPECIAL, SF_MONITOR, mon_op[i]);
			chk({mon_en, mon_ext, mon_chan, mon_pin}, mon_exp[i]);
		end
		$display("test monitor done");
		wr(MODE_SPECIAL, SF_GPIO, 16'h0003);
		chk({gpio_oe, gpio_o}, 24'h3);
		wr(MODE_SPECIAL, SF_GPIO, 16'h0002);
		chk({gpio_oe, gpio_o}, 24'h2);
		wr(MODE_SPECIAL, SF_GPIO, 16'h0000);
		chk(gpio_oe, 24'h0);
		rdb(RB_GPIO, 7'h00, rd);
		chk(rd, 24'h000000);
		gpio_i = 1'b1;
		rdb(RB_GPIO, 7'h00, rd);
		chk(rd, 24'h000001);
		$display("test gpio done");
		for (int s = 0; s < 4; s++)
		begin
			rdb({s[2:0], 6'h05}, 7'h00, rd);
			chk(rd, {8'h00, 4'hA, 3'h0, s[2:0], 6'h05});
			rdb(sys_a[s], 7'h00, rd);
			chk(rd, {8'h00, sys_e[s]});
		end
		$display("test readback done");
		end_sim();
	end
endmodule
bind dsf_decoder dsf_props props_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
	.sync_b_i(sync_b_i), .sdo_o(sdo_o), .gpio_o(gpio_o), .gpio_oe_o(gpio_oe_o),
	.bank_sel_o(bank_sel_o), .mon_en_o(mon_en_o), .mon_ext_o(mon_ext_o),
	.mon_chan_o(mon_chan_o), .mon_pin_o(mon_pin_o), .rb_src_o(rb_src_o));
